// >>> src/srw_ctrl.sv
// Stop-recovery, clock prescaler, reset sequencer and watchdog.
// Assumes all inputs synchronous to sys_clk; sys_rst is the power-on reset.
//
// Contract
// (R1) Recovery flag bit 7 is read-only, set on recovery, cleared by power-on.
// (R2) All other stop-recovery bits are write-only.
// (R3) Bit 6 picks low or high source level as the recovery trigger.
// (R4) Bit 5 picks the reset delay used after a stop recovery.
// (R5) Bits 4..2 pick which input is the recovery source.
// (R6) Bit 0 divides core and timer clocks by 16.
// (R7) Every stop recovery forces the divide-by-16 bit to zero.
// (R8) Watchdog timeout select gives 5, 10, 20 or 80 ms.
// (R9) Watchdog mode bit 2 keeps the watchdog counting in halt; default 1.
// (R10) Watchdog mode bit 3 keeps the watchdog counting in stop; default 1.
// (R11) Software selects the RC clock for the watchdog when used in stop; there is no RC clock here, it counts on sys_clk.
// (R12) Watchdog and 18-clock reset timers start on rising start inputs.
// (R13) A fixed option decides if the watchdog runs after power-on.
// (R14) Brown-out holds the global reset while supply is low.
// (R15) Leaving brown-out runs a full power-on reset sequence.
// (R16) Watchdog timeout resets through the power-on delay path.
`timescale 1ns/1ps
`default_nettype none
module srw_ctrl #(
  parameter int WD_CNT_W = 20,
  parameter int WD_T0 = srw_pkg::WD_T0_CYC,
  parameter int WD_T1 = srw_pkg::WD_T1_CYC,
  parameter int WD_T2 = srw_pkg::WD_T2_CYC,
  parameter int WD_T3 = srw_pkg::WD_T3_CYC,
  parameter int POR_DLY = srw_pkg::POR_DLY_CYC,
  parameter int NUM_SRC = 8
) (
  // Clock and power-on reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Core power state
  input wire logic stop_enter,
  input wire logic halt_mode,
  input wire logic [NUM_SRC-1:0] recovery_src,
  // Reset and watchdog inputs
  input wire logic watchdog_timer_start,
  input wire logic short_reset_timer_start,
  input wire logic wdt_por_option,
  input wire logic brownout_low,
  // Outputs to the core
  output logic core_clk_en,
  output logic timer_interrupt_clock,
  output logic global_reset,
  output logic in_stop,
  output logic irq
);
  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  localparam int DLY_W = 8;
  typedef struct packed {
    srw_pkg::srw_state_t state;
    logic flag;
    logic [6:0] src;
    logic [7:0] wdm;
    logic [srw_pkg::IRQ_W-1:0] ist;
    logic [srw_pkg::IRQ_W-1:0] imsk;
    logic [7:0] rdata;
    logic [srw_pkg::DIV_W-1:0] div_cnt;
    logic [DLY_W-1:0] dly_cnt;
    logic por_seq;
    logic wd_run;
    logic [WD_CNT_W-1:0] wd_cnt;
    logic wts_prev;
    logic srs_prev;
  } srw_regs_t;

  srw_regs_t s_ff;
  srw_regs_t nxt_s;

  // Refuse limits the counters cannot hold
  if (WD_T3 >= (2 ** WD_CNT_W) || WD_T0 < 1 || NUM_SRC != 8 ||
      POR_DLY < 1 || POR_DLY >= (2 ** DLY_W)) begin : g_bad_param
    $error("srw_ctrl: parameter out of range");
  end

  function automatic logic rise(input logic prev, input logic cur);
    rise = cur & ~prev;
  endfunction : rise

  // Watchdog limit, minus one, for the selected timeout
  function automatic logic [WD_CNT_W-1:0] wd_limit(input logic [1:0] sel);
    case (sel)
      2'b00: wd_limit = WD_CNT_W'(WD_T0 - 1);
      2'b01: wd_limit = WD_CNT_W'(WD_T1 - 1);
      2'b10: wd_limit = WD_CNT_W'(WD_T2 - 1);
      default: wd_limit = WD_CNT_W'(WD_T3 - 1);
    endcase
  endfunction : wd_limit

  // ----------------------------------------------------------------
  // Combinational decode
  // ----------------------------------------------------------------
  logic wts_rise;
  logic srs_rise;
  logic src_hit;
  logic recov;
  logic wd_active;
  logic wd_expire;
  logic div_tick;

  // (R12) start on rising edge
  assign wts_rise = rise(s_ff.wts_prev, watchdog_timer_start);
  assign srs_rise = rise(s_ff.srs_prev, short_reset_timer_start);
  // (R3) (R5) selected source, level polarity
  assign src_hit = recovery_src[s_ff.src[srw_pkg::SRC_SEL_LO +: 3]] ==
                   s_ff.src[srw_pkg::SRC_POL_BIT];
  assign recov = (s_ff.state == srw_pkg::ST_STOPPED) & src_hit &
                 ~brownout_low;
  // (R9) (R10) halt and stop gating
  assign wd_active = s_ff.wd_run & ~wts_rise &
    (((s_ff.state == srw_pkg::ST_RUN) &
      ~(halt_mode & ~s_ff.wdm[srw_pkg::WDM_HALT_BIT])) |
     ((s_ff.state == srw_pkg::ST_STOPPED) &
      s_ff.wdm[srw_pkg::WDM_STOP_BIT]));
  // (R8) timeout compare
  assign wd_expire = wd_active & ~brownout_low &
    (s_ff.wd_cnt >= wd_limit(s_ff.wdm[srw_pkg::WDM_TSEL_LO +: 2]));
  // (R6) divide-by-16 tick
  assign div_tick = ~s_ff.src[srw_pkg::SRC_DIV_BIT] |
                    (s_ff.div_cnt == srw_pkg::DIV_LAST);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    nxt_s.wts_prev = watchdog_timer_start;
    nxt_s.srs_prev = short_reset_timer_start;
    nxt_s.div_cnt = s_ff.div_cnt + 4'h1;
    nxt_s.rdata = 8'h00;
    // Register reads
    if (reg_rd) begin
      case (reg_addr)
        // (R1) (R2) only the flag is readable
        srw_pkg::ADDR_STOP_RECOVERY: nxt_s.rdata = {s_ff.flag, 7'h00};
        srw_pkg::ADDR_IRQ_STATUS: nxt_s.rdata = {5'h00, s_ff.ist};
        srw_pkg::ADDR_IRQ_MASK: nxt_s.rdata = {5'h00, s_ff.imsk};
        default: nxt_s.rdata = 8'h00;
      endcase
    end
    // Register writes; hardware events below take priority
    if (reg_wr) begin
      case (reg_addr)
        // (R2) flag bit ignores writes
        srw_pkg::ADDR_STOP_RECOVERY: nxt_s.src = reg_wdata[6:0];
        srw_pkg::ADDR_WDOG_MODE: nxt_s.wdm = reg_wdata;
        srw_pkg::ADDR_IRQ_STATUS: nxt_s.ist = s_ff.ist & ~reg_wdata[2:0];
        srw_pkg::ADDR_IRQ_MASK: nxt_s.imsk = reg_wdata[2:0];
        default: nxt_s.imsk = nxt_s.imsk;
      endcase
    end
    // Watchdog counter
    if (wts_rise) begin
      // (R12) restart on rising start input
      nxt_s.wd_run = 1'b1;
      nxt_s.wd_cnt = '0;
    end else if (wd_active) begin
      nxt_s.wd_cnt = s_ff.wd_cnt + WD_CNT_W'(1);
    end
    // Sequencer
    case (s_ff.state)
      srw_pkg::ST_RUN: begin
        if (wd_expire) begin
          // (R16) timeout uses power-on delay
          nxt_s.state = srw_pkg::ST_DELAY;
          nxt_s.dly_cnt = DLY_W'(POR_DLY);
          nxt_s.por_seq = 1'b1;
          nxt_s.wd_cnt = '0;
          nxt_s.ist[srw_pkg::IRQ_WDOG_BIT] = 1'b1;
        end else if (srs_rise) begin
          // (R12) short reset timer start
          nxt_s.state = srw_pkg::ST_DELAY;
          nxt_s.dly_cnt = DLY_W'(srw_pkg::SHORT_RST_CYC);
          nxt_s.por_seq = 1'b0;
        end else if (stop_enter) begin
          nxt_s.state = srw_pkg::ST_STOPPED;
        end
      end
      srw_pkg::ST_STOPPED: begin
        if (wd_expire) begin
          nxt_s.state = srw_pkg::ST_DELAY;
          nxt_s.dly_cnt = DLY_W'(POR_DLY);
          nxt_s.por_seq = 1'b1;
          nxt_s.wd_cnt = '0;
          nxt_s.ist[srw_pkg::IRQ_WDOG_BIT] = 1'b1;
        end else if (recov) begin
          // (R1) flag set on recovery
          nxt_s.flag = 1'b1;
          // (R7) prescaler bypassed after recovery
          nxt_s.src[srw_pkg::SRC_DIV_BIT] = 1'b0;
          nxt_s.state = srw_pkg::ST_DELAY;
          // (R4) delay choice
          nxt_s.dly_cnt = s_ff.src[srw_pkg::SRC_DLY_BIT] ?
                          DLY_W'(POR_DLY) : DLY_W'(srw_pkg::SHORT_RST_CYC);
          nxt_s.por_seq = 1'b0;
          nxt_s.ist[srw_pkg::IRQ_RECOV_BIT] = 1'b1;
        end
      end
      srw_pkg::ST_DELAY: begin
        nxt_s.dly_cnt = s_ff.dly_cnt - DLY_W'(1);
        if (s_ff.dly_cnt <= DLY_W'(1)) begin
          nxt_s.state = srw_pkg::ST_RUN;
          if (s_ff.por_seq) begin
            // (R13) power-on watchdog option
            nxt_s.wd_run = wdt_por_option;
            nxt_s.wd_cnt = '0;
          end
        end
      end
      srw_pkg::ST_BROWNOUT: begin
        if (!brownout_low) begin
          // (R15) full power-on sequence
          nxt_s.state = srw_pkg::ST_DELAY;
          nxt_s.dly_cnt = DLY_W'(POR_DLY);
          nxt_s.por_seq = 1'b1;
        end
      end
      default: nxt_s.state = srw_pkg::ST_RUN;
    endcase
    // (R14) brown-out overrides all else
    if (brownout_low) begin
      nxt_s.state = srw_pkg::ST_BROWNOUT;
      nxt_s.wd_run = 1'b0;
      nxt_s.wd_cnt = '0;
      nxt_s.ist[srw_pkg::IRQ_BROWN_BIT] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      // Power-on enters the delay path; option is read at its end
      s_ff <= '{state: srw_pkg::ST_DELAY, flag: 1'b0,
                src: srw_pkg::SRC_RST, wdm: srw_pkg::WDM_RST,
                ist: srw_pkg::IRQ_RST, imsk: srw_pkg::IRQ_RST,
                rdata: 8'h00, div_cnt: '0,
                dly_cnt: DLY_W'(POR_DLY), por_seq: 1'b1,
                wd_run: 1'b0, wd_cnt: '0,
                wts_prev: 1'b1, srs_prev: 1'b1};
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata = s_ff.rdata;
  // (R6) both clocks share the prescaler
  assign core_clk_en = div_tick & (s_ff.state == srw_pkg::ST_RUN) &
                       ~halt_mode;
  assign timer_interrupt_clock = div_tick &
                                 (s_ff.state == srw_pkg::ST_RUN);
  // (R14) reset held through delay and brown-out
  assign global_reset = s_ff.state[1];
  assign in_stop = s_ff.state == srw_pkg::ST_STOPPED;
  assign irq = |(s_ff.ist & s_ff.imsk);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_flag_ro;
    @(posedge sys_clk) disable iff (sys_rst)
    (reg_wr && reg_addr == srw_pkg::ADDR_STOP_RECOVERY && !recov)
      |=> s_ff.flag == $past(s_ff.flag);
  endproperty
  a_flag_ro: assert property (p_flag_ro) // R1
    else $error("recovery flag changed by a write");

  property p_wo_read;
    @(posedge sys_clk) disable iff (sys_rst)
    (reg_rd && reg_addr == srw_pkg::ADDR_STOP_RECOVERY)
      |=> reg_rdata[6:0] == 7'h00 && reg_rdata[7] == $past(s_ff.flag);
  endproperty
  a_wo_read: assert property (p_wo_read) // R2
    else $error("write-only bits visible on read");

  property p_recov_go;
    @(posedge sys_clk) disable iff (sys_rst)
    (s_ff.state == srw_pkg::ST_STOPPED && src_hit && !brownout_low &&
     !wd_expire) |=> global_reset && s_ff.flag;
  endproperty
  a_recov_go: assert property (p_recov_go) // R3
    else $error("selected source level did not recover");

  property p_recov_dly;
    @(posedge sys_clk) disable iff (sys_rst)
    (recov && !wd_expire) |=> s_ff.dly_cnt ==
      ($past(s_ff.src[srw_pkg::SRC_DLY_BIT]) ? DLY_W'(POR_DLY) :
       DLY_W'(srw_pkg::SHORT_RST_CYC));
  endproperty
  a_recov_dly: assert property (p_recov_dly) // R4
    else $error("wrong reset delay after recovery");

  property p_div_clr;
    @(posedge sys_clk) disable iff (sys_rst)
    (recov && !wd_expire) |=> !s_ff.src[srw_pkg::SRC_DIV_BIT];
  endproperty
  a_div_clr: assert property (p_div_clr) // R7
    else $error("prescaler not bypassed after recovery");

  property p_halt_hold;
    @(posedge sys_clk) disable iff (sys_rst)
    (s_ff.state == srw_pkg::ST_RUN && halt_mode &&
     !s_ff.wdm[srw_pkg::WDM_HALT_BIT] && !wts_rise && !brownout_low)
      |=> s_ff.wd_cnt == $past(s_ff.wd_cnt);
  endproperty
  a_halt_hold: assert property (p_halt_hold) // R9
    else $error("watchdog counted in halt while disabled");

  property p_brown;
    @(posedge sys_clk) disable iff (sys_rst)
    brownout_low |=> global_reset && s_ff.state == srw_pkg::ST_BROWNOUT;
  endproperty
  a_brown: assert property (p_brown) // R14
    else $error("brown-out did not hold reset");

  property p_brown_por;
    @(posedge sys_clk) disable iff (sys_rst)
    (s_ff.state == srw_pkg::ST_BROWNOUT && !brownout_low)
      |=> s_ff.por_seq && s_ff.dly_cnt == DLY_W'(POR_DLY) && global_reset;
  endproperty
  a_brown_por: assert property (p_brown_por) // R15
    else $error("brown-out exit skipped power-on sequence");

  property p_wd_reset;
    @(posedge sys_clk) disable iff (sys_rst)
    wd_expire |=> s_ff.state == srw_pkg::ST_DELAY && s_ff.por_seq &&
      s_ff.ist[srw_pkg::IRQ_WDOG_BIT];
  endproperty
  a_wd_reset: assert property (p_wd_reset) // R16
    else $error("watchdog timeout did not reset");
endmodule : srw_ctrl
`default_nettype wire

// >>> include/srw_pkg.sv
// Constants for the stop-recovery and watchdog controller.
// Assumes a single 10 MHz core clock and a byte-wide register port.
package srw_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_STOP_RECOVERY = 8'h0b;
  localparam logic [7:0] ADDR_WDOG_MODE = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0d;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0e;
  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int SRC_FLAG_BIT = 7;
  localparam int SRC_POL_BIT = 6;
  localparam int SRC_DLY_BIT = 5;
  localparam int SRC_SEL_LO = 2;
  localparam int SRC_DIV_BIT = 0;
  localparam int WDM_TSEL_LO = 0;
  localparam int WDM_HALT_BIT = 2;
  localparam int WDM_STOP_BIT = 3;
  localparam logic [6:0] SRC_RST = 7'h00;
  localparam logic [7:0] WDM_RST = 8'h0c;
  localparam int IRQ_RECOV_BIT = 0;
  localparam int IRQ_WDOG_BIT = 1;
  localparam int IRQ_BROWN_BIT = 2;
  localparam int IRQ_W = 3;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int WD_T0_MS = 5;
  localparam int WD_T1_MS = 10;
  localparam int WD_T2_MS = 20;
  localparam int WD_T3_MS = 80;
  localparam int WD_T0_CYC = WD_T0_MS * CYC_PER_MS;
  localparam int WD_T1_CYC = WD_T1_MS * CYC_PER_MS;
  localparam int WD_T2_CYC = WD_T2_MS * CYC_PER_MS;
  localparam int WD_T3_CYC = WD_T3_MS * CYC_PER_MS;
  localparam int SHORT_RST_CYC = 18;
  localparam int POR_DLY_CYC = 64;
  localparam int DIV_W = 4;
  localparam logic [DIV_W-1:0] DIV_LAST = 4'hf;
  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_STOPPED = 2'b01,
    ST_DELAY = 2'b10,
    ST_BROWNOUT = 2'b11
  } srw_state_t;
endpackage : srw_pkg

// >>> tb/tb_srw_ctrl.sv
// Self-checking bench for the stop-recovery and watchdog controller.
// Assumes shortened watchdog limits (20/40/80/160) and an 8-cycle POR delay.
`timescale 1ns/1ps
`default_nettype none
module tb_srw_ctrl;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } srw_row_t;
  logic sys_clk, sys_rst, reg_wr, reg_rd, stop_enter, halt_mode;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, recovery_src, v;
  logic watchdog_timer_start, short_reset_timer_start;
  logic wdt_por_option, brownout_low;
  logic core_clk_en, timer_interrupt_clock, global_reset, in_stop, irq;
  int mismatches, n_tests, lat, n, a, b, t;
  srw_row_t rows [6];
  int tv [4] = '{20, 40, 80, 160};

  srw_ctrl #(.WD_T0(20), .WD_T1(40), .WD_T2(80), .WD_T3(160),
    .POR_DLY(8)) u_srw_ctrl (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .stop_enter(stop_enter), .halt_mode(halt_mode),
    .recovery_src(recovery_src),
    .watchdog_timer_start(watchdog_timer_start),
    .short_reset_timer_start(short_reset_timer_start),
    .wdt_por_option(wdt_por_option), .brownout_low(brownout_low),
    .core_clk_en(core_clk_en), .timer_interrupt_clock(timer_interrupt_clock),
    .global_reset(global_reset), .in_stop(in_stop), .irq(irq));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %0h, seen %0h", nm, exp, seen);
    end
  endtask : check

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  task automatic step(input int k);
    repeat (k) begin
      @(posedge sys_clk);
      #1;
    end
  endtask : step

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  // Read data stand only in the cycle after the strobe is taken
  task automatic rd(input logic [7:0] ad, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  // Cycles until reset rises, then cycles it stays high; both bounded
  task automatic rst_len(input int lim, output int l, output int k);
    l = 0;
    k = 0;
    while (global_reset !== 1'b1 && l < lim) begin
      @(posedge sys_clk);
      #1;
      l++;
    end
    while (global_reset === 1'b1 && k < 2000) begin
      k++;
      @(posedge sys_clk);
      #1;
    end
  endtask : rst_len

  task automatic cnt_en(output int ca, output int cb);
    ca = 0;
    cb = 0;
    repeat (32) begin
      @(posedge sys_clk);
      #1;
      ca += (core_clk_en === 1'b1);
      cb += (timer_interrupt_clock === 1'b1);
    end
  endtask : cnt_en

  initial begin
    #(100 * 60000);
    mismatches++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    mismatches = 0;
    n_tests = 0;
    {sys_rst, reg_wr, reg_rd, stop_enter, halt_mode} = 5'h10;
    {reg_addr, reg_wdata, recovery_src} = 24'h000000;
    {watchdog_timer_start, short_reset_timer_start} = 2'h0;
    {wdt_por_option, brownout_low} = 2'h0;
    rows[0] = '{1'b0, 8'h0b, 8'h00, 8'h00};
    rows[1] = '{1'b1, 8'h0b, 8'hff, 8'h00};
    rows[2] = '{1'b1, 8'h0c, 8'h0f, 8'h00};
    rows[3] = '{1'b1, 8'h0e, 8'h07, 8'h07};
    rows[4] = '{1'b1, 8'h20, 8'h55, 8'h00};
    rows[5] = '{1'b1, 8'h0d, 8'h07, 8'h00};
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    #1;
    rst_len(2, lat, n);
    check("por_len", n >= 8 && n <= 9, 1);
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd(rows[i].a, v);
      check("reg_read", v, rows[i].e);
    end
    check("irq_idle", irq, 1'b0);
    // prescaler, divider set by the 0xff write above
    cnt_en(a, b);
    check("core_div", a, 2);
    check("timer_interrupt_clock_div", b, 2);
    @(posedge sys_clk);
    halt_mode <= 1'b1;
    cnt_en(a, b);
    check("core_halt", a, 0);
    check("timer_interrupt_clock_halt", b, 2);
    @(posedge sys_clk);
    halt_mode <= 1'b0;
    wr(8'h0b, 8'h00);
    cnt_en(a, b);
    check("core_full", a, 32);
    // Stop and recovery: high level on source 3 with 18-cycle delay, then
    // low level on source 6 with power-on delay; divider on before each
    for (int r = 0; r < 2; r++) begin
      t = r ? 6 : 3;
      wr(8'h0b, r ? 8'h39 : 8'h4d);
      wr(8'h0e, 8'h01);
      @(posedge sys_clk);
      recovery_src <= {8{r[0]}};
      stop_enter <= 1'b1;
      @(posedge sys_clk);
      stop_enter <= 1'b0;
      #1;
      check("in_stop", in_stop, 1'b1);
      @(posedge sys_clk);
      recovery_src <= {8{~r[0]}} ^ (8'h01 << t);
      step(5);
      // other sources must not wake the core
      check("wrong_src", {in_stop, global_reset}, 2'b10);
      @(posedge sys_clk);
      recovery_src[t] <= ~r[0];
      #1;
      rst_len(5, lat, n);
      check("recov_lat", lat, 1);
      check("recov_dly", n, r ? 8 : 18);
      rd(8'h0b, v);
      check("flag_set", v, 8'h80);
      cnt_en(a, b);
      check("div_clear", a, 32);
      check("irq_recov", irq, 1'b1);
      wr(8'h0d, 8'h01);
      check("irq_clear", irq, 1'b0);
    end
    wr(8'h0b, 8'h00);
    rd(8'h0b, v);
    check("flag_ro", v, 8'h80);
    wr(8'h0e, 8'h02);
    // every timeout select, each ending in a power-on reset delay
    for (int s = 0; s < 4; s++) begin
      wr(8'h0c, 8'h0c | s[7:0]);
      @(posedge sys_clk);
      watchdog_timer_start <= 1'b1;
      halt_mode <= s[0];
      #1;
      rst_len(400, lat, n);
      check("wd_time", lat >= tv[s] - 2 && lat <= tv[s] + 3, 1);
      check("wd_dly", n, 8);
      @(posedge sys_clk);
      watchdog_timer_start <= 1'b0;
      halt_mode <= 1'b0;
    end
    check("irq_wd", irq, 1'b1);
    wr(8'h0d, 8'h07);
    // short reset timer on a rising start; a held level is no edge
    @(posedge sys_clk);
    short_reset_timer_start <= 1'b1;
    #1;
    rst_len(5, lat, n);
    check("short_dly", n, 18);
    step(30);
    check("short_held", global_reset, 1'b0);
    @(posedge sys_clk);
    short_reset_timer_start <= 1'b0;
    // watchdog held off in halt and in stop
    wr(8'h0c, 8'h00);
    @(posedge sys_clk);
    halt_mode <= 1'b1;
    watchdog_timer_start <= 1'b1;
    // Idle sources high, so source 0 stays quiet until released
    recovery_src <= 8'hff;
    #1;
    rst_len(60, lat, n);
    check("wd_halt_rst", lat, 60);
    check("wd_halt", global_reset, 1'b0);
    @(posedge sys_clk);
    halt_mode <= 1'b0;
    stop_enter <= 1'b1;
    @(posedge sys_clk);
    stop_enter <= 1'b0;
    #1;
    rst_len(60, lat, n);
    check("wd_stop_rst", lat, 60);
    check("wd_stop", {in_stop, global_reset}, 2'b10);
    @(posedge sys_clk);
    recovery_src[0] <= 1'b0;
    #1;
    rst_len(5, lat, n);
    check("wake_dly", n, 18);
    rst_len(40, lat, n);
    check("wd_resume", lat >= 1 && lat <= 23, 1);
    check("wd_dly2", n, 8);
    @(posedge sys_clk);
    watchdog_timer_start <= 1'b0;
    // watchdog counts in stop on sys_clk
    wr(8'h0c, 8'h08);
    @(posedge sys_clk);
    watchdog_timer_start <= 1'b1;
    stop_enter <= 1'b1;
    recovery_src <= 8'hff;
    @(posedge sys_clk);
    stop_enter <= 1'b0;
    #1;
    check("wd_stop_in", in_stop, 1'b1);
    rst_len(40, lat, n);
    check("wd_in_stop", lat >= 18 && lat <= 23, 1);
    check("wd_stop_dly", n, 8);
    @(posedge sys_clk);
    watchdog_timer_start <= 1'b0;
    // brown-out holds reset, then a full power-on sequence
    // with the watchdog option on starts the watchdog by itself
    wr(8'h0e, 8'h04);
    @(posedge sys_clk);
    wdt_por_option <= 1'b1;
    brownout_low <= 1'b1;
    step(2);
    repeat (30) begin
      check("bo_hold", global_reset, 1'b1);
      step(1);
    end
    check("irq_bo", irq, 1'b1);
    @(posedge sys_clk);
    brownout_low <= 1'b0;
    #1;
    rst_len(3, lat, n);
    check("bo_por", n >= 8 && n <= 10, 1);
    rst_len(40, lat, n);
    check("wd_por_on", lat >= 18 && lat <= 23, 1);
    wr(8'h0d, 8'h07);
    check("irq_bo_clr", irq, 1'b0);
    rd(8'h0b, v);
    check("flag_bo", v, 8'h80);
    // only a power-on cycle clears the flag
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    wdt_por_option <= 1'b0;
    step(2);
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    #1;
    rst_len(2, lat, n);
    rd(8'h0b, v);
    check("flag_por", v, 8'h00);
    rd(8'h0e, v);
    check("mask_rst", v, 8'h00);
    step(60);
    check("wd_por_off", global_reset, 1'b0);
    end_of_test();
  end
endmodule : tb_srw_ctrl
`default_nettype wire
